// ==== src/upcrs_regs.svh ====
// upcrs_regs.svh: timing counts, idle byte and level reset value for the clock/reset
// start-up block; assumes a 125 MHz system clock at the link end.
// Function
// RULE1 - sample clock strap at start-up, pick mode
// RULE2 - link gives 60 MHz clock, ties strap high
// RULE3 - dir held until pll lock; link waits
// RULE4 - output mode: drive 60 MHz clock after lock
// RULE5 - link leaves strap low for output mode
// RULE6 - no phase relation reference to interface clock
// RULE7 - only rising reference edges matter
// RULE8 - late reference clock delays start equally
// RULE9 - reset pin low blocks start-up
// RULE10 - stop reference only after last write
// RULE11 - stp exits low power; restart clock with it
// RULE12 - stopped reference drops pll lock; here pll_locked holds its value while the reference is stopped
// RULE13 - regulators on only while reset pin high
// RULE14 - power-on reset pulse after core supply stable
// RULE15 - reset pin low 1 us resets everything
// RULE16 - link always drives reset pin level
// RULE17 - uart regulator level from two-bit field
// RULE18 - host sets automatic resume bit
// RULE19 - dir stays high while stp held high
// RULE20 - link drives idle 00h one cycle after dir
`ifndef UPCRS_REGS_SVH
`define UPCRS_REGS_SVH
`define UPCRS_CLK_SYS_MHZ 125
`define UPCRS_RESET_LOW_NS 1000
// least time rounds up
`define UPCRS_RESET_LOW_CYC ((`UPCRS_RESET_LOW_NS*`UPCRS_CLK_SYS_MHZ+999)/1000)
`define UPCRS_LOCK_CYC 64
`define UPCRS_POR_CYC 16
`define UPCRS_LOSS_CYC 8
`define UPCRS_CLKDIV_HALF 1
`define UPCRS_IDLE_DATA 8'h00
`define UPCRS_REG_LEVEL_RST 2'h0
`endif

// ==== src/upcrs_pkg.sv ====
// upcrs_pkg.sv: state types shared by both ends.
// assumes nothing beyond a SystemVerilog compiler.
package upcrs_pkg;
    typedef enum logic [2:0] {
        DEV_OFF = 3'b000,
        DEV_POR = 3'b001,
        DEV_LOCK = 3'b011,
        DEV_STP = 3'b010,
        DEV_RUN = 3'b110,
        DEV_LOWP = 3'b111
    } upcrs_dev_state_t;
    typedef enum logic [1:0] {
        LNK_RESET = 2'b00,
        LNK_WAIT = 2'b01,
        LNK_IDLE = 2'b11,
        LNK_RUN = 2'b10
    } upcrs_lnk_state_t;
endpackage : upcrs_pkg

// ==== src/upcrs_if.sv ====
// upcrs_if.sv: pins between the transceiver start-up logic and the link.
// the bench supplies the reference clock and the bus resolution.
`timescale 1ns/1ns
`default_nettype none
interface upcrs_if;
    logic reference_clock_input;
    logic chip_reset_pin_low_active;
    logic strap_o;
    logic strap_oe;
    logic strap_i;
    logic dir;
    logic stp;
    logic [7:0] data_o;
    logic data_oe;
    // strap wire: driven clock in output mode, else tie from the link
    modport dev (
        input reference_clock_input, chip_reset_pin_low_active, strap_i, stp,
        output strap_o, strap_oe, dir
    );
    modport lnk (
        input dir, strap_i,
        output chip_reset_pin_low_active, stp, data_o, data_oe
    );
endinterface : upcrs_if
`default_nettype wire

// ==== src/upcrs_dev.sv ====
// upcrs_dev.sv: transceiver end; clock mode strap, pll lock, dir, regs.
// assumes reference clock from the link/bench; pll lock is modelled by
// counting reference edges, as the analog loop is outside this block.
`timescale 1ns/1ns
`default_nettype none
`include "upcrs_regs.svh"
module upcrs_dev #(
    parameter int LOCK_CYC = `UPCRS_LOCK_CYC
) (
    // link pins
    upcrs_if.dev pins,
    // supply and user side
    input wire logic core_supply_1v8,
    input wire logic uart_mode,
    input wire logic [1:0] uart_regulator_level,
    input wire logic low_power_req,
    output logic clock_input_mode,
    output logic pll_locked,
    output logic regulators_enable,
    output logic regulator_pulldown,
    output logic [1:0] regulator_level,
    output logic iface_running
);
    // reset pin and supply are not clocked by us; rule 7: posedge only
    logic rclk;
    logic [2:0] rst_sync_r;
    logic [2:0] sup_sync_r;
    logic [2:0] stp_sync_r;
    logic [7:0] por_r, por_nxt;
    logic [15:0] lock_r, lock_nxt;
    logic mode_r, mode_nxt;
    logic [1:0] lvl_r, lvl_nxt;
    logic div_r, div_nxt;
    logic dir_r, dir_nxt;
    upcrs_pkg::upcrs_dev_state_t st_r, st_nxt;
    logic rst_hi;
    logic sup_ok;
    logic stp_hi;
    assign rclk = pins.reference_clock_input; // [RULE7]
    // no reference edges means no start-up: late clock delays equally
    assign rst_hi = rst_sync_r[1] & rst_sync_r[2]; // [RULE8] [RULE9]
    assign sup_ok = sup_sync_r[1] & sup_sync_r[2];
    assign stp_hi = stp_sync_r[1] & stp_sync_r[2];

    // three-stage synchronisers for pin inputs
    always_ff @(posedge rclk) begin
        rst_sync_r <= {rst_sync_r[1:0], pins.chip_reset_pin_low_active};
        sup_sync_r <= {sup_sync_r[1:0], core_supply_1v8};
        stp_sync_r <= {stp_sync_r[1:0], pins.stp};
    end

    // regulators follow the reset pin level directly, clock not needed
    assign regulators_enable = pins.chip_reset_pin_low_active; // [RULE13]
    assign regulator_pulldown = ~pins.chip_reset_pin_low_active; // [RULE13]

    // start-up sequencer next state
    always_comb begin
        st_nxt = st_r;
        por_nxt = por_r;
        lock_nxt = lock_r;
        mode_nxt = mode_r;
        lvl_nxt = lvl_r;
        dir_nxt = dir_r;
        if (uart_mode) begin
            lvl_nxt = uart_regulator_level; // [RULE17]
        end
        unique case (st_r)
            upcrs_pkg::DEV_OFF: begin
                dir_nxt = 1'b0;
                lvl_nxt = `UPCRS_REG_LEVEL_RST;
                por_nxt = '0;
                if (rst_hi && sup_ok) begin // [RULE9] [RULE14]
                    st_nxt = upcrs_pkg::DEV_POR;
                end
            end
            upcrs_pkg::DEV_POR: begin
                // internal power-on pulse, then strap sampled at its end
                por_nxt = por_r + 8'h01; // [RULE14]
                if (por_r == 8'(`UPCRS_POR_CYC)) begin
                    mode_nxt = pins.strap_i; // [RULE1]
                    lock_nxt = '0;
                    dir_nxt = 1'b1;
                    st_nxt = upcrs_pkg::DEV_LOCK;
                end
            end
            upcrs_pkg::DEV_LOCK: begin
                lock_nxt = lock_r + 16'h0001;
                if (lock_r == 16'(LOCK_CYC)) begin
                    st_nxt = upcrs_pkg::DEV_STP; // [RULE3]
                end
            end
            upcrs_pkg::DEV_STP: begin
                if (!stp_hi) begin // [RULE19]
                    dir_nxt = 1'b0; // [RULE3] [RULE4]
                    st_nxt = upcrs_pkg::DEV_RUN;
                end
            end
            upcrs_pkg::DEV_RUN: begin
                if (low_power_req) begin
                    st_nxt = upcrs_pkg::DEV_LOWP;
                end
            end
            upcrs_pkg::DEV_LOWP: begin
                // stp wakes the part; lock is rebuilt from scratch
                if (stp_hi) begin // [RULE11]
                    lock_nxt = '0;
                    dir_nxt = 1'b1;
                    st_nxt = upcrs_pkg::DEV_LOCK;
                end
            end
            default: begin
                st_nxt = upcrs_pkg::DEV_OFF;
            end
        endcase
        if (!rst_hi || !sup_ok) begin // [RULE15]
            st_nxt = upcrs_pkg::DEV_OFF;
        end
    end

    // pin reset may come without a reference clock; async clear holds dir
    always_ff @(posedge rclk or negedge pins.chip_reset_pin_low_active) begin
        if (!pins.chip_reset_pin_low_active) begin // [RULE15]
            st_r <= upcrs_pkg::DEV_OFF;
            por_r <= '0;
            lock_r <= '0;
            mode_r <= 1'b0;
            lvl_r <= `UPCRS_REG_LEVEL_RST;
            dir_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            por_r <= por_nxt;
            lock_r <= lock_nxt;
            mode_r <= mode_nxt;
            lvl_r <= lvl_nxt;
            dir_r <= dir_nxt;
        end
    end

    // clock divider: output clock toggles on each rising reference edge, so it follows reference phase
    always_comb begin
        div_nxt = ~div_r; // [RULE6]
    end
    always_ff @(posedge rclk or negedge pins.chip_reset_pin_low_active) begin
        if (!pins.chip_reset_pin_low_active) begin
            div_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
        end
    end

    // stopped reference freezes every counter here, so pll_locked holds; lock is
    // rebuilt only through the low-power or reset path [RULE12]
    assign pll_locked = (st_r == upcrs_pkg::DEV_STP)
        || (st_r == upcrs_pkg::DEV_RUN);
    assign clock_input_mode = mode_r;
    assign regulator_level = lvl_r;
    assign iface_running = (st_r == upcrs_pkg::DEV_RUN);
    assign pins.dir = dir_r;
    // drive generated clock only in output mode and only once locked
    assign pins.strap_oe = ~mode_r & pll_locked; // [RULE4]
    assign pins.strap_o = div_r;
endmodule : upcrs_dev
`default_nettype wire

// ==== src/upcrs_lnk.sv ====
// upcrs_lnk.sv: link end; drives reset pin, stp and idle data.
// assumes clk_sys at 125 MHz and dir arriving from the transceiver.
`timescale 1ns/1ns
`default_nettype none
`include "upcrs_regs.svh"
module upcrs_lnk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // link pins
    upcrs_if.lnk pins,
    // user side
    input wire logic start_req,
    input wire logic wake_req,
    output logic link_ready,
    output logic host_resume_automatic
);
    logic [2:0] dir_sync_r;
    logic dir_hi;
    logic [7:0] cnt_r, cnt_nxt;
    logic rstpin_r, rstpin_nxt;
    logic stp_r, stp_nxt;
    logic seen_r, seen_nxt;
    upcrs_pkg::upcrs_lnk_state_t st_r, st_nxt;

    // three-stage synchroniser, high only while stages two and three are both high
    always_ff @(posedge clk_sys) begin
        dir_sync_r <= {dir_sync_r[1:0], pins.dir};
    end
    assign dir_hi = dir_sync_r[1] & dir_sync_r[2];

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        rstpin_nxt = rstpin_r;
        stp_nxt = 1'b0;
        seen_nxt = seen_r;
        unique case (st_r)
            upcrs_pkg::LNK_RESET: begin
                rstpin_nxt = 1'b0; // [RULE16]
                // saturate so a late start request is not lost to a wrap
                if (cnt_r != 8'hFF) begin
                    cnt_nxt = cnt_r + 8'h01;
                end
                if (cnt_r >= 8'(`UPCRS_RESET_LOW_CYC) && start_req) begin
                    rstpin_nxt = 1'b1; // [RULE15]
                    seen_nxt = 1'b0;
                    st_nxt = upcrs_pkg::LNK_WAIT;
                end
            end
            upcrs_pkg::LNK_WAIT: begin
                // no traffic until dir has risen and fallen again
                // a wake stp is held until dir answers: a one-cycle pulse
                // could fall between two reference edges and be missed
                stp_nxt = stp_r & ~dir_hi; // [RULE11] [RULE19]
                if (dir_hi) begin
                    seen_nxt = 1'b1;
                end else if (seen_r) begin // [RULE3]
                    st_nxt = upcrs_pkg::LNK_IDLE;
                end
            end
            upcrs_pkg::LNK_IDLE: begin
                st_nxt = upcrs_pkg::LNK_RUN; // [RULE20]
            end
            upcrs_pkg::LNK_RUN: begin
                if (wake_req) begin
                    stp_nxt = 1'b1; // [RULE11]
                    seen_nxt = 1'b0;
                    st_nxt = upcrs_pkg::LNK_WAIT;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_r <= upcrs_pkg::LNK_RESET;
            cnt_r <= '0;
            rstpin_r <= 1'b0;
            stp_r <= 1'b0;
            seen_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            rstpin_r <= rstpin_nxt;
            stp_r <= stp_nxt;
            seen_r <= seen_nxt;
        end
    end

    assign pins.chip_reset_pin_low_active = rstpin_r; // [RULE16]
    assign pins.stp = stp_r;
    // idle byte on the bus once dir is released [RULE20]
    assign pins.data_o = `UPCRS_IDLE_DATA;
    assign pins.data_oe = (st_r == upcrs_pkg::LNK_IDLE)
        || (st_r == upcrs_pkg::LNK_RUN);
    assign link_ready = (st_r == upcrs_pkg::LNK_RUN);
    assign host_resume_automatic = 1'b1; // [RULE18]
    // strap and reference clock ties are board level [RULE2] [RULE5]
endmodule : upcrs_lnk
`default_nettype wire

// ==== verification/upcrs_assertions.sv ====
// upcrs_assertions.sv: timing checks on the start-up pins of one link.
// assumes clk_sys/reset of the link end and the pins of one interface.
`timescale 1ns/1ns
`default_nettype none
module upcrs_assertions (
    // clocks and resets
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic reference_clock_input,
    input wire logic chip_reset_pin_low_active,
    // pins
    input wire logic strap_o,
    input wire logic strap_oe,
    input wire logic strap_i,
    input wire logic dir,
    input wire logic stp,
    input wire logic [7:0] data_o,
    input wire logic data_oe
);
    logic [7:0] low_cnt_r;
    logic [7:0] low_cnt_nxt;
    // reset pin low time in clk_sys cycles, saturating
    always_comb begin
        low_cnt_nxt = low_cnt_r;
        if (chip_reset_pin_low_active) low_cnt_nxt = 8'h00;
        else if (low_cnt_r != 8'hFF) low_cnt_nxt = low_cnt_r + 8'h01;
    end
    always_ff @(posedge clk_sys) low_cnt_r <= reset ? 8'h00 : low_cnt_nxt;
    // link side, clk_sys domain
    property p_rst_len; @(posedge clk_sys) disable iff (reset)
        $rose(chip_reset_pin_low_active) |-> low_cnt_r >= 8'h7D; endproperty
    a_rst_len: assert property (p_rst_len) else $error("reset pin short");
    property p_dir_rst; @(posedge clk_sys) disable iff (reset)
        !chip_reset_pin_low_active |-> !dir; endproperty
    a_dir_rst: assert property (p_dir_rst) else $error("dir in reset");
    property p_idle; @(posedge clk_sys) disable iff (reset)
        data_oe |-> data_o == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("idle byte not zero");
    property p_oe_dir; @(posedge clk_sys) disable iff (reset)
        $rose(data_oe) |-> !dir && !$past(dir, 2) ##1 data_oe; endproperty
    a_oe_dir: assert property (p_oe_dir) else $error("bus before dir");
    // device side, reference clock domain
    property p_dir_min; @(posedge reference_clock_input)
        disable iff (!chip_reset_pin_low_active) $rose(dir) |=> dir [*8]; endproperty
    a_dir_min: assert property (p_dir_min) else $error("dir short");
    property p_dir_stp; @(posedge reference_clock_input)
        disable iff (!chip_reset_pin_low_active) $fell(dir) |-> !$past(stp, 3); endproperty
    a_dir_stp: assert property (p_dir_stp) else $error("dir fell on stp");
    property p_strap; @(posedge reference_clock_input)
        disable iff (!chip_reset_pin_low_active) $rose(strap_oe) |-> !$past(strap_i);
    endproperty
    a_strap: assert property (p_strap) else $error("clock on high strap");
    property p_clk_run; @(posedge reference_clock_input)
        disable iff (!chip_reset_pin_low_active)
        strap_oe && $past(strap_oe) |-> strap_o != $past(strap_o); endproperty
    a_clk_run: assert property (p_clk_run) else $error("clock stalled");
    // main scenarios reached
    c_dir_fall: cover property (@(posedge clk_sys) $fell(dir));
    c_oe_rise: cover property (@(posedge clk_sys) $rose(data_oe));
    c_strap_oe: cover property (@(posedge clk_sys) $rose(strap_oe));
endmodule : upcrs_assertions
`default_nettype wire

// ==== verification/test_ulpi_phy_clock_reset_startup.sv ====
// test_ulpi_phy_clock_reset_startup.sv: both ends joined, plus a spare
// device end driven directly; assumes 125 MHz clk_sys, 15 ns reference.
`timescale 1ns/1ns
`default_nettype none
module test_ulpi_phy_clock_reset_startup;
    typedef struct {logic t; logic u; logic [1:0] l; logic [1:0] el;} upcrs_row_t;
    logic clk_sys = 1'b0, reset = 1'b1, ref_clk = 1'b0, ref_en2 = 1'b1;
    logic tie = 1'b0, start_req = 1'b0, wake_req = 1'b0, uart_mode = 1'b0;
    logic rst2 = 1'b0, stp2 = 1'b0, core2 = 1'b1, lp2 = 1'b0;
    logic [1:0] lvl = 2'h0;
    logic [1:0] rlvl;
    logic cim, ren, run, ready, hra, ren2, rpd2, run2, lock, lock2;
    logic lp1 = 1'b0;
    int n_mismatch = 0, total_checks = 0;
    // strap tie, uart mode, level field, level expected
    upcrs_row_t rows [4] = '{'{1'b0, 1'b0, 2'h3, 2'h0}, '{1'b1, 1'b1, 2'h2, 2'h2},
        '{1'b0, 1'b1, 2'h1, 2'h1}, '{1'b1, 1'b0, 2'h3, 2'h0}};
    // clocks: reference unrelated in phase to clk_sys
    initial forever #4 clk_sys = ~clk_sys;
    initial begin
        #3;
        forever begin
            #7 ref_clk = 1'b1;
            #8 ref_clk = 1'b0;
        end
    end
    // pins; the strap wire is the device clock when enabled, else the tie
    upcrs_if i_pins ();
    upcrs_if i_pins2 ();
    assign i_pins.reference_clock_input = ref_clk;
    assign i_pins.strap_i = i_pins.strap_oe ? i_pins.strap_o : tie;
    assign i_pins2.reference_clock_input = ref_clk & ref_en2;
    assign i_pins2.strap_i = i_pins2.strap_oe ? i_pins2.strap_o : 1'b0;
    assign i_pins2.chip_reset_pin_low_active = rst2;
    assign i_pins2.stp = stp2;
    upcrs_dev #(.LOCK_CYC(8)) i_upcrs_dev (.pins(i_pins.dev),
        .core_supply_1v8(1'b1), .uart_mode(uart_mode),
        .uart_regulator_level(lvl), .low_power_req(lp1),
        .clock_input_mode(cim), .pll_locked(lock), .regulators_enable(ren),
        .regulator_pulldown(), .regulator_level(rlvl), .iface_running(run));
    upcrs_lnk i_upcrs_lnk (.clk_sys(clk_sys), .reset(reset), .pins(i_pins.lnk),
        .start_req(start_req), .wake_req(wake_req), .link_ready(ready),
        .host_resume_automatic(hra));
    upcrs_dev #(.LOCK_CYC(8)) i_upcrs_dev_b (.pins(i_pins2.dev),
        .core_supply_1v8(core2), .uart_mode(uart_mode),
        .uart_regulator_level(lvl), .low_power_req(lp2),
        .clock_input_mode(), .pll_locked(lock2), .regulators_enable(ren2),
        .regulator_pulldown(rpd2), .regulator_level(), .iface_running(run2));
    upcrs_assertions i_upcrs_assertions (.clk_sys(clk_sys), .reset(reset),
        .reference_clock_input(i_pins.reference_clock_input),
        .chip_reset_pin_low_active(i_pins.chip_reset_pin_low_active),
        .strap_o(i_pins.strap_o), .strap_oe(i_pins.strap_oe),
        .strap_i(i_pins.strap_i), .dir(i_pins.dir), .stp(i_pins.stp),
        .data_o(i_pins.data_o), .data_oe(i_pins.data_oe));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test
    task automatic chk_bit(input string nm, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit
    task automatic chk_lvl(input string nm, input logic [1:0] e, input logic [1:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_lvl
    // bounded wait, sampled mid-cycle so edge updates have landed
    task automatic wait_on(input int s, input logic v);
        int k = 0;
        // let the edge that launched the request settle before looking
        @(negedge clk_sys);
        while ((s == 0 ? ready : s == 1 ? i_pins2.dir
            : s == 2 ? run2 : run) !== v) begin
            @(negedge clk_sys);
            k++;
            if (k == 3000) begin
                n_mismatch++;
                $display("MISMATCH wait %0d expected %b seen timeout", s, v);
                end_of_test();
            end
        end
    endtask : wait_on
    // main sequence
    initial begin
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        foreach (rows[i]) begin
            @(posedge clk_sys);
            {start_req, reset} <= 2'b01;
            {tie, uart_mode, lvl} <= {rows[i].t, rows[i].u, rows[i].l};
            @(posedge clk_sys);
            {start_req, reset} <= 2'b10;
            wait_on(0, 1'b1);
            chk_bit("clock_input_mode", rows[i].t, cim);
            chk_bit("strap_oe", !rows[i].t, i_pins.strap_oe);
            chk_lvl("regulator_level", rows[i].el, rlvl);
            chk_bit("regulators_enable", 1'b1, ren);
            chk_bit("iface_running", 1'b1, run);
            chk_bit("host_resume", 1'b1, hra);
            chk_bit("data_oe", 1'b1, i_pins.data_oe);
            chk_bit("reset_pin", 1'b1, i_pins.chip_reset_pin_low_active);
            chk_bit("pll_locked", 1'b1, lock);
        end
        // joined pair: low power, then the link wakes it with stp
        @(posedge clk_sys);
        lp1 <= 1'b1;
        wait_on(3, 1'b0);
        @(posedge clk_sys);
        {lp1, wake_req} <= 2'b01;
        @(posedge clk_sys);
        wake_req <= 1'b0;
        @(negedge clk_sys);
        chk_bit("link_ready", 1'b0, ready);
        wait_on(0, 1'b1);
        chk_bit("link_ready", 1'b1, ready);
        chk_bit("iface_running", 1'b1, run);
        chk_bit("dir2", 1'b0, i_pins2.dir);
        chk_bit("regulators_enable2", 1'b0, ren2);
        chk_bit("regulator_pulldown2", 1'b1, rpd2);
        // pin up with no reference yet and stp held: nothing may start
        @(posedge clk_sys);
        {ref_en2, stp2, rst2} <= 3'b011;
        repeat (100) @(negedge clk_sys);
        chk_bit("dir2", 1'b0, i_pins2.dir);
        @(posedge clk_sys);
        ref_en2 <= 1'b1;
        wait_on(1, 1'b1);
        repeat (150) @(negedge clk_sys);
        chk_bit("dir2", 1'b1, i_pins2.dir);
        @(posedge clk_sys);
        stp2 <= 1'b0;
        wait_on(1, 1'b0);
        wait_on(2, 1'b1);
        chk_bit("strap_oe2", 1'b1, i_pins2.strap_oe);
        // low power, reference stopped, woken by stp with the clock
        @(posedge clk_sys);
        lp2 <= 1'b1;
        wait_on(2, 1'b0);
        @(posedge clk_sys);
        ref_en2 <= 1'b0;
        repeat (40) @(posedge clk_sys);
        chk_bit("pll_locked2", 1'b0, lock2);
        {stp2, ref_en2, lp2} <= 3'b110;
        repeat (20) @(posedge clk_sys);
        stp2 <= 1'b0;
        wait_on(2, 1'b1);
        chk_bit("iface_running2", 1'b1, run2);
        // core supply loss forces the device off until it returns
        @(posedge clk_sys);
        core2 <= 1'b0;
        repeat (20) @(negedge clk_sys);
        chk_bit("iface_running2", 1'b0, run2);
        @(posedge clk_sys);
        core2 <= 1'b1;
        wait_on(2, 1'b1);
        end_of_test();
    end
endmodule : test_ulpi_phy_clock_reset_startup
`default_nettype wire
